/* core/ccs_params.svh */
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

`define R_PMODE 16'h0001
`define R_STATUS 16'h0003
`define R_EXPO 16'h0005
`define R_FPS 16'h000a
`define R_SMODE 16'h0019
`define R_CMD 16'h0033
`define R_MAC0 16'h0040
`define R_MAC1 16'h0041
`define R_MAC2 16'h0042
`define R_IP_HI 16'h0043
`define R_IP_LO 16'h0044
`define R_PORT 16'h0045
`define R_KA_TO 16'h004e
`define R_KA_KEY 16'h004f

`define PM_VIDEO_BIT 0
`define PM_SLEEP_BIT 2
`define PM_SWTRIG_BIT 4
`define PM_CLRST_BIT 6
`define SM_AEC_BIT 3
`define SM_ILLUM_BIT 12
`define ST_BOOTLDR_BIT 0
`define ST_READY_BIT 1
`define ST_FACTORY_BIT 6

`define PMODE_RST 16'h0001
`define SMODE_RST 16'h0000
`define EXPO_RST 16'h05dc
`define FPS_RST 16'h002d
`define KA_TO_RST 16'h0000

`define KA_KEY 16'hca82
`define CMD_SAVE 16'h0001
`define CMD_ERASE 16'h0002

`define BL_IP_HI 16'hc0a8
`define BL_IP_LO 16'h000a
`define BL_PORT 16'h2711

`define CLK_PERIOD_NS 10
`define US_NS 1000
`define US_CYCLES (`US_NS / `CLK_PERIOD_NS)
`define SEC_NS 1000000000
`define SEC_CYCLES (`SEC_NS / `CLK_PERIOD_NS)
`define EXPO_MAX_MS 27
`define EXPO_MAX_US (`EXPO_MAX_MS * 1000)
`define FPS_MAX 45
`define US_PER_SEC 1000000
`define TEMP_LIMIT_C 90
`define SYNC_WAIT 2

`endif

/* core/ccs_pkg.sv */
package ccs_pkg;

   typedef enum logic [1:0] {BOOT_WAIT, BOOT_SAMPLE, BOOT_RUN} boot_st_t;

   typedef struct packed {
      logic [15:0] pmode;
      logic [15:0] smode;
      logic [15:0] expo;
      logic [15:0] fps;
      logic [15:0] ka_to;
      logic [15:0] mac2;
      logic [15:0] mac1;
      logic [15:0] mac0;
      logic [15:0] ip_hi;
      logic [15:0] ip_lo;
      logic [15:0] port;
   } regmap_img_t;

   typedef struct packed {
      regmap_img_t rm;
      regmap_img_t img_out;
      logic [15:0] act_ip_hi;
      logic [15:0] act_ip_lo;
      logic [15:0] act_port;
      logic [47:0] act_mac;
      logic illum_ext;
      logic boot_ldr;
      logic factory_ld;
      boot_st_t bst;
      logic [1:0] wait_cnt;
      logic [1:0] bs_sync;
      logic [1:0] trig_sync;
      logic trig_prev;
      logic hw_pend;
      logic [6:0] us_cnt;
      logic [19:0] rate_acc;
      logic rate_due;
      logic [14:0] expo_cnt;
      logic busy;
      logic paused;
      logic frame_ready;
      logic frame_start;
      logic [15:0] expo_app;
      logic [15:0] rdata;
      logic rvalid;
      logic save_p;
      logic erase_p;
      logic key_p;
      logic reboot_p;
   } sup_state_t;

   typedef struct packed {
      logic armed;
      logic expired;
      logic [31:0] cyc;
      logic [15:0] sec;
   } wdg_state_t;

endpackage : ccs_pkg

/* core/ka_if.sv */
`timescale 1ns/1ns
interface ka_if;
   logic [15:0] timeout_s;
   logic key_ok;
   logic expired;
   modport sup (output timeout_s, output key_ok, input expired);
   modport wdg (input timeout_s, input key_ok, output expired);
endinterface : ka_if

/* core/keepalive_watchdog.sv */
`timescale 1ns/1ns
`include "ccs_params.svh"
module keepalive_watchdog #(
   parameter logic [31:0] CYC_PER_SEC = `SEC_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   ka_if.wdg ka
);
   import ccs_pkg::*;

   wdg_state_t st_ff;
   wdg_state_t nxt_st;
   logic [16:0] sec_next;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.expired = 1'b0;
      sec_next = {1'b0, st_ff.sec} + 17'h00001;
      if (ka.key_ok) begin
         // every good key restarts the full window
         nxt_st.armed = 1'b1;
         nxt_st.cyc = 32'h0;
         nxt_st.sec = 16'h0;
      end else if (st_ff.armed && ka.timeout_s != 16'h0) begin
         if (st_ff.cyc == CYC_PER_SEC - 32'h1) begin
            nxt_st.cyc = 32'h0;
            if (sec_next >= {1'b0, ka.timeout_s}) begin
               nxt_st.expired = 1'b1;
               nxt_st.armed = 1'b0;
               nxt_st.sec = 16'h0;
            end else begin
               nxt_st.sec = sec_next[15:0];
            end
         end else begin
            nxt_st.cyc = st_ff.cyc + 32'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign ka.expired = st_ff.expired;

endmodule : keepalive_watchdog

/* core/camera_control_supervisor.sv */
`timescale 1ns/1ns
`include "ccs_params.svh"
// Behaviour
// - applied exposure never exceeds 27 ms
// - frame rate capped at 45 fps
// - auto exposure owns exposure, host writes ignored
// - manual mode: hardware trigger starts frame
// - manual mode: writing bit 4 starts one frame
// - pause capture at 90 C, resume below
// - nonzero timeout enables link supervision
// - missed key within timeout reboots device
// - timeout counted in whole seconds
// - count only after first key since reboot
// - saved image includes keepalive timeout
// - illumination select applies after reboot only
// - store command saves, reboot restores map
// - erase command restores factory on reboot
// - user MAC overrides factory, saved or lost
// - IP and port changes apply on reconnect, MAC at once
// - boot: firmware unless missing or strapped
// - bootstrap sampled right after startup
// - bootloader uses factory network settings only
// - bit 0 selects manual or video
module camera_control_supervisor #(
   parameter logic [31:0] CYC_PER_SEC = `SEC_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic trig_pin,
   input wire logic bootstrap_pin,
   input wire logic [7:0] led_temp_c,
   input wire logic [15:0] aec_expo_us,
   input wire logic fw_valid,
   input wire logic [47:0] factory_mac,
   input wire logic flash_img_valid,
   input wire ccs_pkg::regmap_img_t flash_img,
   input wire logic reconnect,
   output logic flash_save,
   output logic flash_erase,
   output ccs_pkg::regmap_img_t flash_img_out,
   output logic frame_start,
   output logic capture_active,
   output logic capture_paused,
   output logic [15:0] exposure_us_applied,
   output logic illum_ext_sel,
   output logic bootloader_mode,
   output logic boot_done,
   output logic [47:0] mac_addr,
   output logic [31:0] ip_addr,
   output logic [15:0] ctrl_port,
   output logic reboot_req
);
   import ccs_pkg::*;

   function automatic logic [15:0] umin16(
      input logic [15:0] a,
      input logic [15:0] b
   );
      return (a < b) ? a : b;
   endfunction : umin16

   function automatic regmap_img_t factory_img(input logic [47:0] mac);
      regmap_img_t r;
      r.pmode = `PMODE_RST;
      r.smode = `SMODE_RST;
      r.expo = `EXPO_RST;
      r.fps = `FPS_RST;
      r.ka_to = `KA_TO_RST;
      r.mac2 = mac[47:32];
      r.mac1 = mac[31:16];
      r.mac0 = mac[15:0];
      r.ip_hi = `BL_IP_HI;
      r.ip_lo = `BL_IP_LO;
      r.port = `BL_PORT;
      return r;
   endfunction : factory_img

   function automatic sup_state_t reset_state();
      sup_state_t s;
      s = '0;
      s.rm = factory_img(48'h0);
      s.img_out = factory_img(48'h0);
      s.act_ip_hi = `BL_IP_HI;
      s.act_ip_lo = `BL_IP_LO;
      s.act_port = `BL_PORT;
      s.bst = BOOT_WAIT;
      return s;
   endfunction : reset_state

   sup_state_t st_ff;
   sup_state_t nxt_st;
   logic [15:0] fps_eff;
   logic [15:0] expo_src;
   logic [15:0] expo_lim;
   logic [20:0] acc_sum;
   logic us_tick;
   logic hw_edge;
   logic running;
   logic video;
   logic want;
   logic start;
   logic done_now;
   logic go_bl;
   logic aec_on;

   ka_if ka ();

   keepalive_watchdog #(
      .CYC_PER_SEC(CYC_PER_SEC)
   ) u_wdg (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .ka(ka)
   );

   assign ka.timeout_s = st_ff.rm.ka_to;
   assign ka.key_ok = st_ff.key_p;

   always_comb begin
      nxt_st = st_ff;
      aec_on = st_ff.rm.smode[`SM_AEC_BIT];
      fps_eff = umin16(st_ff.rm.fps, 16'(`FPS_MAX));
      expo_src = aec_on ? aec_expo_us : st_ff.rm.expo;
      expo_lim = umin16(expo_src, 16'(`EXPO_MAX_US));
      acc_sum = {1'b0, st_ff.rate_acc} + {5'h00, fps_eff};
      us_tick = (st_ff.us_cnt == 7'(`US_CYCLES - 1));
      hw_edge = st_ff.trig_sync[1] & ~st_ff.trig_prev;
      running = (st_ff.bst == BOOT_RUN) && !st_ff.boot_ldr;
      video = st_ff.rm.pmode[`PM_VIDEO_BIT];
      go_bl = st_ff.bs_sync[1] | ~fw_valid;
      want = 1'b0;
      start = 1'b0;
      done_now = 1'b0;

      // first stage feeds only the second
      nxt_st.bs_sync = {st_ff.bs_sync[0], bootstrap_pin};
      nxt_st.trig_sync = {st_ff.trig_sync[0], trig_pin};
      nxt_st.trig_prev = st_ff.trig_sync[1];

      nxt_st.frame_start = 1'b0;
      nxt_st.rvalid = 1'b0;
      nxt_st.save_p = 1'b0;
      nxt_st.erase_p = 1'b0;
      nxt_st.key_p = 1'b0;
      nxt_st.reboot_p = 1'b0;
      nxt_st.paused = (led_temp_c >= 8'(`TEMP_LIMIT_C));
      nxt_st.expo_app = expo_lim;
      nxt_st.us_cnt = us_tick ? 7'h00 : st_ff.us_cnt + 7'h01;
      nxt_st.act_mac = st_ff.boot_ldr ? factory_mac :
         {st_ff.rm.mac2, st_ff.rm.mac1, st_ff.rm.mac0};

      case (st_ff.bst)
         BOOT_WAIT: begin
            // let the strap reach the second sync stage first
            nxt_st.wait_cnt = st_ff.wait_cnt + 2'h1;
            if (st_ff.wait_cnt == 2'(`SYNC_WAIT - 1)) begin
               nxt_st.bst = BOOT_SAMPLE;
            end
         end
         BOOT_SAMPLE: begin
            nxt_st.boot_ldr = go_bl;
            if (!go_bl && flash_img_valid) begin
               nxt_st.rm = flash_img;
               nxt_st.factory_ld = 1'b0;
            end else begin
               nxt_st.rm = factory_img(factory_mac);
               nxt_st.factory_ld = 1'b1;
            end
            nxt_st.act_ip_hi = nxt_st.rm.ip_hi;
            nxt_st.act_ip_lo = nxt_st.rm.ip_lo;
            nxt_st.act_port = nxt_st.rm.port;
            // active mac must be right once boot_done rises
            nxt_st.act_mac = go_bl ? factory_mac :
               {nxt_st.rm.mac2, nxt_st.rm.mac1, nxt_st.rm.mac0};
            nxt_st.illum_ext = nxt_st.rm.smode[`SM_ILLUM_BIT];
            nxt_st.bst = BOOT_RUN;
         end
         BOOT_RUN: begin
            nxt_st.bst = BOOT_RUN;
         end
         default: begin
            nxt_st.bst = BOOT_WAIT;
         end
      endcase

      if (running) begin
         // a frame in flight completes unless the keepalive expires; only new starts pause
         if (!st_ff.busy && !st_ff.paused &&
             !st_ff.rm.pmode[`PM_SLEEP_BIT]) begin
            if (video) begin
               want = st_ff.rate_due;
            end else begin
               want = st_ff.hw_pend |
                  st_ff.rm.pmode[`PM_SWTRIG_BIT];
            end
         end
         start = want;
         if (start) begin
            nxt_st.busy = 1'b1;
            nxt_st.expo_cnt = expo_lim[14:0];
            nxt_st.frame_start = 1'b1;
            nxt_st.rate_due = 1'b0;
            nxt_st.hw_pend = 1'b0;
            nxt_st.rm.pmode[`PM_SWTRIG_BIT] = 1'b0;
         end
         if (us_tick) begin
            if (video) begin
               // rate by accumulation avoids a divider
               if (acc_sum >= 21'(`US_PER_SEC)) begin
                  nxt_st.rate_acc = 20'(acc_sum - 21'(`US_PER_SEC));
                  nxt_st.rate_due = 1'b1;
               end else begin
                  nxt_st.rate_acc = acc_sum[19:0];
               end
            end
            // long exposure holds busy, so rate falls
            if (st_ff.busy) begin
               if (st_ff.expo_cnt == 15'h0000) begin
                  nxt_st.busy = 1'b0;
                  nxt_st.frame_ready = 1'b1;
                  done_now = 1'b1;
               end else begin
                  nxt_st.expo_cnt = st_ff.expo_cnt - 15'h0001;
               end
            end
         end
         if (!video && hw_edge && !st_ff.paused) begin
            nxt_st.hw_pend = 1'b1;
         end
      end

      if (reg_rd) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = 16'h0000;
         case (reg_addr)
            `R_PMODE: nxt_st.rdata = st_ff.rm.pmode;
            `R_STATUS: begin
               nxt_st.rdata[`ST_BOOTLDR_BIT] = st_ff.boot_ldr;
               nxt_st.rdata[`ST_READY_BIT] = st_ff.frame_ready;
               nxt_st.rdata[`ST_FACTORY_BIT] = st_ff.factory_ld;
            end
            `R_EXPO: nxt_st.rdata = st_ff.expo_app;
            `R_FPS: nxt_st.rdata = st_ff.rm.fps;
            `R_SMODE: nxt_st.rdata = st_ff.rm.smode;
            `R_MAC0: nxt_st.rdata = st_ff.rm.mac0;
            `R_MAC1: nxt_st.rdata = st_ff.rm.mac1;
            `R_MAC2: nxt_st.rdata = st_ff.rm.mac2;
            `R_IP_HI: nxt_st.rdata = st_ff.rm.ip_hi;
            `R_IP_LO: nxt_st.rdata = st_ff.rm.ip_lo;
            `R_PORT: nxt_st.rdata = st_ff.rm.port;
            `R_KA_TO: nxt_st.rdata = st_ff.rm.ka_to;
            default: nxt_st.rdata = 16'h0000;
         endcase
      end

      // writes before boot completes would be overwritten by restore
      if (reg_wr && st_ff.bst == BOOT_RUN) begin
         case (reg_addr)
            `R_PMODE: begin
               nxt_st.rm.pmode = reg_wdata;
               nxt_st.rm.pmode[`PM_CLRST_BIT] = 1'b0;
               if (reg_wdata[`PM_CLRST_BIT] && !done_now) begin
                  nxt_st.frame_ready = 1'b0;
               end
            end
            `R_EXPO: begin
               if (!aec_on) begin
                  nxt_st.rm.expo = reg_wdata;
               end
            end
            `R_FPS: nxt_st.rm.fps = reg_wdata;
            `R_SMODE: nxt_st.rm.smode = reg_wdata;
            `R_MAC0: nxt_st.rm.mac0 = reg_wdata;
            `R_MAC1: nxt_st.rm.mac1 = reg_wdata;
            `R_MAC2: nxt_st.rm.mac2 = reg_wdata;
            `R_IP_HI: nxt_st.rm.ip_hi = reg_wdata;
            `R_IP_LO: nxt_st.rm.ip_lo = reg_wdata;
            `R_PORT: nxt_st.rm.port = reg_wdata;
            `R_KA_TO: nxt_st.rm.ka_to = reg_wdata;
            `R_KA_KEY: begin
               if (reg_wdata == `KA_KEY) begin
                  nxt_st.key_p = 1'b1;
               end
            end
            `R_CMD: begin
               if (reg_wdata == `CMD_SAVE) begin
                  nxt_st.save_p = 1'b1;
                  nxt_st.img_out = st_ff.rm;
               end else if (reg_wdata == `CMD_ERASE) begin
                  nxt_st.erase_p = 1'b1;
               end
            end
            default: begin
               nxt_st.rm = nxt_st.rm;
            end
         endcase
      end

      if (reconnect && running) begin
         nxt_st.act_ip_hi = st_ff.rm.ip_hi;
         nxt_st.act_ip_lo = st_ff.rm.ip_lo;
         nxt_st.act_port = st_ff.rm.port;
      end

      // soft reboot: unsaved settings are dropped by the restore
      if (ka.expired) begin
         nxt_st.reboot_p = 1'b1;
         nxt_st.bst = BOOT_WAIT;
         nxt_st.wait_cnt = 2'h0;
         nxt_st.busy = 1'b0;
         nxt_st.hw_pend = 1'b0;
         nxt_st.rate_due = 1'b0;
         nxt_st.rate_acc = 20'h00000;
         nxt_st.key_p = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= reset_state();
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign reg_rvalid = st_ff.rvalid;
   assign flash_save = st_ff.save_p;
   assign flash_erase = st_ff.erase_p;
   assign flash_img_out = st_ff.img_out;
   assign frame_start = st_ff.frame_start;
   assign capture_active = st_ff.busy;
   assign capture_paused = st_ff.paused;
   assign exposure_us_applied = st_ff.expo_app;
   assign illum_ext_sel = st_ff.illum_ext;
   assign bootloader_mode = st_ff.boot_ldr;
   assign boot_done = (st_ff.bst == BOOT_RUN);
   assign mac_addr = st_ff.act_mac;
   assign ip_addr = {st_ff.act_ip_hi, st_ff.act_ip_lo};
   assign ctrl_port = st_ff.act_port;
   assign reboot_req = st_ff.reboot_p;

endmodule : camera_control_supervisor

/* bench/ccs_chk.sv */
`timescale 1ns/1ns
`include "ccs_params.svh"
module ccs_chk #(
   parameter logic [31:0] CYC_PER_SEC = 20
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_rvalid,
   input wire logic [7:0] led_temp_c,
   input wire logic fw_valid,
   input wire logic [47:0] factory_mac,
   input wire logic flash_save,
   input wire logic flash_erase,
   input wire logic frame_start,
   input wire logic capture_paused,
   input wire logic [15:0] exposure_us_applied,
   input wire logic bootloader_mode,
   input wire logic boot_done,
   input wire logic [47:0] mac_addr,
   input wire logic [31:0] ip_addr,
   input wire logic [15:0] ctrl_port,
   input wire logic reboot_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence cmd_wr(logic [15:0] v);
      ce && reg_wr && boot_done && reg_addr == `R_CMD && reg_wdata == v;
   endsequence
   // boot walks wait, wait, sample before the block runs
   sequence boot_end;
      !boot_done ##[1:4] boot_done;
   endsequence
   expo_cap_a: assert property (exposure_us_applied <= 16'h6978)
      else $error("applied exposure above limit");
   pause_hot_a: assert property (ce && led_temp_c >= 8'h5a |=> capture_paused)
      else $error("capture not paused when hot");
   pause_cool_a: assert property (ce && led_temp_c < 8'h5a |=> !capture_paused)
      else $error("capture paused below limit");
   frame_once_a: assert property (frame_start |=> !frame_start)
      else $error("frame start longer than one cycle");
   save_cmd_a: assert property (cmd_wr(`CMD_SAVE) |=> flash_save)
      else $error("store command without save pulse");
   erase_cmd_a: assert property (cmd_wr(`CMD_ERASE) |=> flash_erase)
      else $error("erase command without erase pulse");
   boot_seq_a: assert property ($fell(rst) |-> boot_end)
      else $error("boot decision not made in time");
   fw_boot_a: assert property ($rose(boot_done) && !fw_valid
      |-> ##[0:1] bootloader_mode)
      else $error("started without firmware");
   ldr_net_a: assert property (boot_done && bootloader_mode
      && $past(bootloader_mode) |-> ip_addr == 32'hc0a8000a
      && ctrl_port == 16'h2711 && mac_addr == factory_mac)
      else $error("bootloader network settings not factory");
   reboot_a: assert property (reboot_req |-> ##[0:1] !boot_done)
      else $error("expiry did not restart boot");
   read_ans_a: assert property (ce && reg_rd |=> reg_rvalid)
      else $error("read without answer");
endmodule : ccs_chk

bind camera_control_supervisor ccs_chk #(.CYC_PER_SEC(CYC_PER_SEC)) ccs_chk_i (
   .clk_sys, .rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid,
   .led_temp_c, .fw_valid, .factory_mac, .flash_save, .flash_erase,
   .frame_start, .capture_paused, .exposure_us_applied, .bootloader_mode,
   .boot_done, .mac_addr, .ip_addr, .ctrl_port, .reboot_req);

/* bench/flash_model.sv */
`timescale 1ns/1ns
module flash_model (
   input wire logic clk_sys,
   input wire logic flash_save,
   input wire logic flash_erase,
   input wire ccs_pkg::regmap_img_t flash_img_out,
   output logic flash_img_valid,
   output ccs_pkg::regmap_img_t flash_img
);
   import ccs_pkg::*;
   regmap_img_t store_ff = '0;
   logic valid_ff = 1'b0;
   // nonvolatile: no reset, survives every reboot
   always @(posedge clk_sys) begin
      if (flash_save) begin
         store_ff <= flash_img_out;
         valid_ff <= 1'b1;
      end else if (flash_erase) begin
         valid_ff <= 1'b0;
      end
   end
   // erased image shows a pattern so stale data cannot look valid
   assign flash_img = valid_ff ? store_ff : ~store_ff;
   assign flash_img_valid = valid_ff;
endmodule : flash_model

/* bench/tb_camera_control_supervisor.sv */
`timescale 1ns/1ns
`include "ccs_params.svh"
module tb_camera_control_supervisor;
   import ccs_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
   logic [15:0] aec_expo_us = 16'h0064, ctrl_port, exposure_us_applied;
   logic trig_pin = 1'b0, bootstrap_pin = 1'b0, fw_valid = 1'b1, ce = 1'b1;
   logic reconnect = 1'b0, reg_rvalid, flash_img_valid, flash_save;
   logic flash_erase, frame_start, capture_active, capture_paused;
   logic illum_ext_sel, bootloader_mode, boot_done, reboot_req;
   logic [7:0] led_temp_c = 8'h19;
   // factory address value is arbitrary
   logic [47:0] factory_mac = 48'h0a0b0c0d0e0f, mac_addr;
   logic [31:0] ip_addr;
   regmap_img_t flash_img, flash_img_out;
   int fail_count = 0, num_checks = 0, nstarts = 0, nrb = 0, n0, i;
   localparam logic [15:0] DA [9] = '{`R_PMODE, `R_STATUS, `R_EXPO, `R_FPS,
      `R_SMODE, `R_KA_TO, `R_KA_KEY, `R_CMD, 16'h00ff};
   localparam logic [15:0] DV [9] = '{16'h0001, 16'h0040, 16'h05dc,
      16'h002d, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   camera_control_supervisor #(.CYC_PER_SEC(32'd20))
   camera_control_supervisor_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .trig_pin(trig_pin), .bootstrap_pin(bootstrap_pin),
      .led_temp_c(led_temp_c), .aec_expo_us(aec_expo_us),
      .fw_valid(fw_valid), .factory_mac(factory_mac),
      .flash_img_valid(flash_img_valid), .flash_img(flash_img),
      .reconnect(reconnect), .flash_save(flash_save),
      .flash_erase(flash_erase), .flash_img_out(flash_img_out),
      .frame_start(frame_start), .capture_active(capture_active),
      .capture_paused(capture_paused),
      .exposure_us_applied(exposure_us_applied),
      .illum_ext_sel(illum_ext_sel), .bootloader_mode(bootloader_mode),
      .boot_done(boot_done), .mac_addr(mac_addr), .ip_addr(ip_addr),
      .ctrl_port(ctrl_port), .reboot_req(reboot_req));
   flash_model flash_model_i (.clk_sys(clk_sys), .flash_save(flash_save),
      .flash_erase(flash_erase), .flash_img_out(flash_img_out),
      .flash_img_valid(flash_img_valid), .flash_img(flash_img));

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (frame_start === 1'b1) nstarts <= nstarts + 1;
      if (reboot_req === 1'b1) nrb <= nrb + 1;
   end

   task chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk("read valid", 1, reg_rvalid);
      chk($sformatf("register %h", a), e, reg_rdata & m);
   endtask : rd
   task wait_boot;
      for (int k = 0; k < 20 && boot_done !== 1'b1; k++) cyc(1);
      chk("boot done", 1, boot_done);
   endtask : wait_boot
   task boot(input logic strap, input logic fw);
      bootstrap_pin <= strap;
      fw_valid <= fw;
      rst <= 1'b1;
      cyc(6);
      rst <= 1'b0;
      wait_boot();
   endtask : boot
   task wait_idle;
      for (int k = 0; k < 7000 && capture_active !== 1'b0; k++) cyc(1);
      chk("capture idle", 0, capture_active);
   endtask : wait_idle
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   initial begin
      #500000;
      fail_count++;
      summarize();
   end

   initial begin
      boot(1'b0, 1'b1);
      for (i = 0; i < 9; i++) rd(DA[i], DV[i], 16'hffff);
      $display("test defaults done");
      // a write taken while ce is low must leave no trace
      ce <= 1'b0;
      wr(`R_FPS, 16'h0010);
      ce <= 1'b1;
      rd(`R_FPS, 16'h002d, 16'hffff);
      wr(`R_EXPO, 16'h7530);
      rd(`R_EXPO, 16'h6978, 16'hffff);
      wr(`R_EXPO, 16'h0032);
      wr(`R_SMODE, 16'h0008);
      aec_expo_us <= 16'hffff;
      cyc(3);
      chk("auto exposure", 16'h6978, exposure_us_applied);
      wr(`R_EXPO, 16'h0040);
      wr(`R_SMODE, 16'h0000);
      cyc(3);
      chk("manual exposure", 16'h0032, exposure_us_applied);
      $display("test exposure done");
      n0 = nstarts;
      wr(`R_PMODE, 16'h0010);
      cyc(4);
      chk("sw frames", n0 + 1, nstarts);
      rd(`R_PMODE, 16'h0000, 16'hffff);
      wait_idle();
      rd(`R_STATUS, 16'h0002, 16'h0002);
      wr(`R_PMODE, 16'h0040);
      rd(`R_STATUS, 16'h0000, 16'h0002);
      n0 = nstarts;
      trig_pin <= 1'b1;
      cyc(8);
      trig_pin <= 1'b0;
      chk("hw frames", n0 + 1, nstarts);
      wait_idle();
      wr(`R_PMODE, 16'h0001);
      n0 = nstarts;
      trig_pin <= 1'b1;
      cyc(8);
      trig_pin <= 1'b0;
      cyc(8);
      chk("video hw frames", n0, nstarts);
      wr(`R_PMODE, 16'h0000);
      led_temp_c <= 8'h5a;
      n0 = nstarts;
      wr(`R_PMODE, 16'h0010);
      cyc(20);
      chk("hot frames", n0, nstarts);
      chk("paused", 1, capture_paused);
      led_temp_c <= 8'h59;
      cyc(6);
      chk("resumed frames", n0 + 1, nstarts);
      wait_idle();
      $display("test frames done");
      wr(`R_MAC0, 16'h0001);
      wr(`R_MAC1, 16'h0002);
      wr(`R_MAC2, 16'h0003);
      cyc(2);
      chk("user mac", 48'h000300020001, mac_addr);
      wr(`R_IP_LO, 16'h0063);
      cyc(2);
      chk("ip held", 32'hc0a8000a, ip_addr);
      reconnect <= 1'b1;
      cyc(1);
      reconnect <= 1'b0;
      cyc(2);
      chk("ip applied", 32'hc0a80063, ip_addr);
      wr(`R_SMODE, 16'h1000);
      cyc(2);
      chk("illum before reboot", 0, illum_ext_sel);
      wr(`R_KA_TO, 16'h0001);
      wr(`R_CMD, `CMD_SAVE);
      cyc(2);
      chk("saved timeout", 1, flash_img_out.ka_to);
      cyc(60);
      chk("unarmed reboots", 0, nrb);
      wr(`R_KA_KEY, `KA_KEY);
      cyc(8);
      wr(`R_KA_KEY, 16'hca83);
      // a wrong key must not restart the one second window
      for (i = 0; i < 40 && reboot_req !== 1'b1; i++) cyc(1);
      chk("reboot delay", 1, i >= 10 && i <= 14);
      wait_boot();
      rd(`R_KA_TO, 16'h0001, 16'hffff);
      chk("illum after reboot", 1, illum_ext_sel);
      chk("restored mac", 48'h000300020001, mac_addr);
      rd(`R_STATUS, 16'h0000, 16'h0041);
      cyc(60);
      chk("rearm reboots", 1, nrb);
      $display("test keepalive done");
      boot(1'b1, 1'b1);
      chk("strap loader", 1, bootloader_mode);
      chk("loader mac", factory_mac, mac_addr);
      chk("loader ip", 32'hc0a8000a, ip_addr);
      chk("loader port", 16'h2711, ctrl_port);
      rd(`R_STATUS, 16'h0001, 16'h0001);
      boot(1'b0, 1'b0);
      chk("no fw loader", 1, bootloader_mode);
      boot(1'b0, 1'b1);
      chk("fw runs", 0, bootloader_mode);
      chk("app mac", 48'h000300020001, mac_addr);
      wr(`R_CMD, `CMD_ERASE);
      cyc(2);
      chk("flash erased", 0, flash_img_valid);
      boot(1'b0, 1'b1);
      chk("factory mac", factory_mac, mac_addr);
      rd(`R_KA_TO, 16'h0000, 16'hffff);
      rd(`R_STATUS, 16'h0040, 16'h0041);
      $display("test boot done");
      summarize();
   end
endmodule : tb_camera_control_supervisor
